/* rtl/osc_gfx_ctrl.sv */
// Graphics controller end: serves source lines on request.
// Assumes software reaches it through a plain strobe register port.
`timescale 1ns/1ps
module osc_gfx_ctrl
  import osc_pkg::*;
#(
  parameter int PIX_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  osc_link_if.gfx link,
  input wire logic frame_start,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  import osc_pkg::*;
  logic enable;
  logic [9:0] spp;
  logic [9:0] gx;
  logic [9:0] sline;
  logic [7:0] host_rdata;
  logic fwd_rd;
  logic [PIX_W-1:0] buf_mem [0:GFX_BUF_DEPTH-1];
  logic [1:0] buf_cnt;
  logic buf_wp;
  logic buf_rp;

  // Device window forwarded; test locations are never reached
  wire fwd = reg_addr >= GFX_FWD_BASE && reg_addr < OSC_REG_TEST_A;
  assign link.reg_addr = reg_addr;
  assign link.reg_wdata = reg_wdata;
  assign link.reg_wr = reg_wr && fwd;
  assign link.reg_rd = reg_rd && fwd;
  assign reg_rdata = fwd_rd ? link.reg_rdata : host_rdata;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      enable <= 1'b0;
      spp <= GFX_PIX_RESET;
    end else if (reg_wr) begin
      if (reg_addr == GFX_REG_CTRL) enable <= reg_wdata[0];
      if (reg_addr == GFX_REG_PIX_LO) spp[7:0] <= {reg_wdata[7:1], 1'b0};
      if (reg_addr == GFX_REG_PIX_HI) spp[9:8] <= reg_wdata[1:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      host_rdata <= 8'h00;
      fwd_rd <= 1'b0;
    end else begin
      fwd_rd <= reg_rd && fwd;
      case (reg_addr)
        GFX_REG_CTRL: host_rdata <= {7'h00, enable};
        GFX_REG_PIX_LO: host_rdata <= spp[7:0];
        GFX_REG_PIX_HI: host_rdata <= {6'h00, spp[9:8]};
        GFX_REG_LINES: host_rdata <= sline[7:0];
        default: host_rdata <= 8'h00;
      endcase
      if (!reg_rd) host_rdata <= 8'h00;
    end
  end

  // Pixel source: pushes one line per request, stalled by the buffer
  wire push = enable && link.request && gx < spp
    && buf_cnt < 2'(GFX_BUF_DEPTH);
  wire pop = link.pix_valid && link.pix_ready;
  always_ff @(posedge clk_sys) begin
    if (rst || frame_start) begin
      gx <= 10'h000;
      sline <= 10'h000;
    end else if (link.line_start_strobe) begin
      gx <= 10'h000;
    end else if (push) begin
      gx <= gx + 10'h001;
      if (gx + 10'h001 == spp) sline <= sline + 10'h001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) buf_mem[buf_wp] <= PIX_W'(gx + sline);
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      buf_cnt <= 2'b00;
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
    end else begin
      if (push) buf_wp <= !buf_wp;
      if (pop) buf_rp <= !buf_rp;
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
    end
  end
  assign link.pix_valid = buf_cnt != 2'b00;
  assign link.pix_data = buf_mem[buf_rp];
endmodule

/* rtl/osc_link_if.sv */
// Link between the scan converter and the graphics controller.
// Assumes both ends share clk_sys and the synchronous reset rst.
`timescale 1ns/1ps
interface osc_link_if #(parameter int PIX_W = 8) (
  input wire logic clk_sys,
  input wire logic rst
);
  logic line_start_strobe;
  logic request;
  logic pix_valid;
  logic pix_ready;
  logic [PIX_W-1:0] pix_data;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  modport dev (
    input clk_sys, rst, pix_valid, pix_data, reg_addr, reg_wdata,
    input reg_wr, reg_rd,
    output line_start_strobe, request, pix_ready, reg_rdata
  );
  modport gfx (
    input clk_sys, rst, line_start_strobe, request, pix_ready,
    input reg_rdata,
    output pix_valid, pix_data, reg_addr, reg_wdata, reg_wr, reg_rd
  );
endinterface

/* rtl/osc_pkg.sv */
// Shared constants for the overscan scan converter and its pixel source.
// Assumes both ends run on one pixel-rate clock, clk_sys.
package osc_pkg;
  localparam logic [7:0] OSC_REG_CTRL = 8'h90;
  localparam logic [7:0] OSC_REG_SRC_LINES = 8'h91;
  localparam logic [7:0] OSC_REG_SRC_PIX = 8'h92;
  localparam logic [7:0] OSC_REG_SRC_HIGH = 8'h93;
  localparam logic [7:0] OSC_REG_DST_LINES = 8'h94;
  localparam logic [7:0] OSC_REG_DST_PIX = 8'h95;
  localparam logic [7:0] OSC_REG_DST_HIGH = 8'h96;
  localparam logic [7:0] OSC_REG_VRATIO_LO = 8'h97;
  localparam logic [7:0] OSC_REG_VRATIO_HI = 8'h98;
  localparam logic [7:0] OSC_REG_HRATIO_LO = 8'h99;
  localparam logic [7:0] OSC_REG_HRATIO_HI = 8'h9a;
  localparam logic [7:0] OSC_REG_IMAGE_VERTICAL_OFFSET = 8'h9b;
  localparam logic [7:0] OSC_REG_IMAGE_HORIZONTAL_OFFSET = 8'h9c;
  localparam logic [7:0] OSC_REG_LINE_DELAY = 8'h9d;
  localparam logic [7:0] OSC_REG_TEST_A = 8'h9e;
  localparam logic [7:0] OSC_REG_TEST_C = 8'ha0;
  localparam int OSC_NUM_CFG = 14;
  localparam logic [7:0] OSC_CTRL_RESET = 8'h00;
  localparam logic [7:0] OSC_CFG_RESET = 8'h00;
  localparam int OSC_SCN_BIT = 0;
  localparam int OSC_VSC_LSB = 1;
  localparam int OSC_HSC_LSB = 3;
  localparam int OSC_SWAP_BIT = 5;
  localparam int OSC_HIGH_LINES_LSB = 0;
  localparam int OSC_HIGH_PIX_LSB = 4;
  localparam logic [1:0] OSC_MODE_OFF = 2'b00;
  localparam logic [1:0] OSC_MODE_NEAREST = 2'b01;
  localparam logic [1:0] OSC_MODE_FILT_A = 2'b10;
  localparam logic [1:0] OSC_MODE_FILT_B = 2'b11;
  localparam int OSC_IMAGE_HORIZONTAL_OFFSET_SHIFT = 2;
  localparam int OSC_IMAGE_VERTICAL_OFFSET_FIELD_SHIFT = 1;
  localparam int OSC_IMAGE_VERTICAL_OFFSET_FRAME_SHIFT = 2;
  localparam int OSC_FRAC_W = 16;
  localparam int OSC_LBUF_LINES = 4;
  localparam logic [7:0] GFX_REG_CTRL = 8'h00;
  localparam logic [7:0] GFX_REG_PIX_LO = 8'h01;
  localparam logic [7:0] GFX_REG_PIX_HI = 8'h02;
  localparam logic [7:0] GFX_REG_LINES = 8'h03;
  localparam logic [7:0] GFX_FWD_BASE = 8'h90;
  localparam logic [9:0] GFX_PIX_RESET = 10'h000;
  localparam int GFX_BUF_DEPTH = 2;
endpackage

/* rtl/osc_scaler_dev.sv */
// Overscan scaler and progressive-to-interlace converter.
// Assumes the raster logic pulses dst_line_start once per output line
// and field_start once per output field, all on clk_sys.
`timescale 1ns/1ps
// What this block does
// - Field swap exchanges odd and even fields
// - Horizontal mode: off, nearest, square-law blend
// - Vertical mode: off, nearest, two 3-tap filters
// - Scan enable turns frames into interlaced fields
// - Source lines: 10 bits, low and high registers
// - Source pixels: 10 bits, bit 0 zero
// - Destination lines: 10 bits, low and high
// - Destination pixels: 10 bits, bit 0 zero
// - Software loads vertical ratio step
// - Software loads horizontal ratio step
// - Vertical offset in two-line field units
// - Horizontal offset in four-pixel units
// - Request waits delay + 1 cycles after strobe
// - Controller must supply pixels once requested
// - Software leaves test registers alone
// - Delay counted in pixel clock cycles
module osc_scaler_dev
  import osc_pkg::*;
#(
  parameter int PIX_W = 8,
  parameter int MAX_PIX = 1024
) (
  input wire logic clk_sys,
  input wire logic rst,
  osc_link_if.dev link,
  input wire logic dst_line_start,
  input wire logic field_start,
  input wire logic field_odd,
  output logic [PIX_W-1:0] out_pix,
  output logic out_valid,
  output logic out_field,
  output logic busy
);
  import osc_pkg::*;
  typedef enum logic [2:0] {
    ST_IDLE, ST_STROBE, ST_WAIT, ST_FETCH, ST_OUT
  } osc_state_e;
  typedef logic [25:0] osc_pos_t;

  osc_state_e state;
  logic [7:0] cfg [0:OSC_NUM_CFG-1];
  logic [7:0] idx;
  logic [PIX_W-1:0] lbuf [0:OSC_LBUF_LINES*MAX_PIX-1];
  logic [7:0] dly_cnt;
  logic [9:0] wx;
  logic [9:0] src_got;
  logic [10:0] dline;
  logic [10:0] ocnt;
  logic blank_line;
  logic odd_eff;
  osc_pos_t vacc;
  osc_pos_t hacc;

  wire progressive_to_interlace_enable = cfg[0][OSC_SCN_BIT];
  wire [1:0] vmode = cfg[0][OSC_VSC_LSB +: 2];
  wire [1:0] hmode = cfg[0][OSC_HSC_LSB +: 2];
  wire [7:0] hi_s = cfg[3];
  wire [7:0] hi_d = cfg[6];
  wire [9:0] src_lines = {hi_s[OSC_HIGH_LINES_LSB +: 2], cfg[1]};
  wire [9:0] src_pix = {hi_s[OSC_HIGH_PIX_LSB +: 2], cfg[2]};
  wire [9:0] dst_lines = {hi_d[OSC_HIGH_LINES_LSB +: 2], cfg[4]};
  wire [9:0] dst_pix = {hi_d[OSC_HIGH_PIX_LSB +: 2], cfg[5]};
  wire [15:0] vratio = {cfg[8], cfg[7]};
  wire [15:0] hratio = {cfg[10], cfg[9]};
  wire [7:0] image_vertical_offset = cfg[11];
  wire [7:0] image_horizontal_offset = cfg[12];
  wire [7:0] line_request_delay = cfg[13];

  // Register port; test locations and unmapped addresses read zero
  assign idx = link.reg_addr - OSC_REG_CTRL;
  wire in_cfg = link.reg_addr >= OSC_REG_CTRL
    && link.reg_addr <= OSC_REG_LINE_DELAY;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < OSC_NUM_CFG; i++) begin
        cfg[i] <= (i == 0) ? OSC_CTRL_RESET : OSC_CFG_RESET;
      end
    end else if (link.reg_wr && in_cfg) begin
      cfg[idx[3:0]] <= link.reg_wdata;
      if (link.reg_addr == OSC_REG_SRC_PIX
          || link.reg_addr == OSC_REG_DST_PIX) begin
        cfg[idx[3:0]] <= {link.reg_wdata[7:1], 1'b0};
      end
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      link.reg_rdata <= 8'h00;
    end else if (link.reg_rd && in_cfg) begin
      link.reg_rdata <= cfg[idx[3:0]];
    end else begin
      link.reg_rdata <= 8'h00;
    end
  end

  // Steps in 10.16; interlace doubles the vertical step
  wire [16:0] vbase = (vmode == OSC_MODE_OFF) ? 17'h10000
    : {1'b0, vratio} + 17'h10000;
  wire osc_pos_t vstep = progressive_to_interlace_enable ? osc_pos_t'({vbase, 1'b0})
    : osc_pos_t'(vbase);
  wire [16:0] hstep = (hmode == OSC_MODE_OFF || hmode == OSC_MODE_FILT_B)
    ? 17'h10000 : {1'b0, hratio} + 17'h10000;
  wire [10:0] voff = progressive_to_interlace_enable ? {3'b000, image_vertical_offset} << OSC_IMAGE_VERTICAL_OFFSET_FIELD_SHIFT
    : {3'b000, image_vertical_offset} << OSC_IMAGE_VERTICAL_OFFSET_FRAME_SHIFT;
  wire [10:0] vlines = progressive_to_interlace_enable ? {2'b00, dst_lines[9:1]}
    : {1'b0, dst_lines};
  wire [10:0] hoff = {3'b000, image_horizontal_offset} << OSC_IMAGE_HORIZONTAL_OFFSET_SHIFT;
  wire [10:0] oend = hoff + {1'b0, dst_pix};
  wire line_on = dline >= voff && dline < voff + vlines;
  wire [9:0] vint = vacc[25:16];
  wire need_more = src_got <= vint + 10'd1 && src_got < src_lines;

  // Output rows clamped to lines already held, columns to the source width
  wire [9:0] r_p = (vint == 10'd0) ? vint : vint - 10'd1;
  wire [9:0] r_n = (vint + 10'd1 >= src_got) ? vint : vint + 10'd1;
  wire [9:0] cx = hacc[25:16];
  wire [9:0] cx1 = (cx + 10'd1 >= src_pix) ? cx : cx + 10'd1;

  function automatic logic [PIX_W-1:0] vmix(
    input logic [PIX_W-1:0] p,
    input logic [PIX_W-1:0] c,
    input logic [PIX_W-1:0] n,
    input logic [1:0] mode,
    input logic half
  );
    logic [PIX_W+2:0] s;
    s = '0;
    case (mode)
      OSC_MODE_NEAREST: vmix = half ? n : c;
      OSC_MODE_FILT_A: begin
        s = {3'b000, p} + {2'b00, c, 1'b0} + {3'b000, n};
        vmix = s[PIX_W+1:2];
      end
      OSC_MODE_FILT_B: begin
        s = {3'b000, p} + {1'b0, c, 2'b00} + {2'b00, c, 1'b0}
          + {3'b000, n};
        vmix = s[PIX_W+2:3];
      end
      default: vmix = c;
    endcase
  endfunction

  function automatic logic [PIX_W-1:0] row(input logic [9:0] r,
                                           input logic [9:0] x);
    row = lbuf[{r[1:0], x}];
  endfunction

  wire vhalf = vacc[15];
  wire [PIX_W-1:0] va = vmix(row(r_p, cx), row(vint, cx),
    row(r_n, cx), vmode, vhalf);
  wire [PIX_W-1:0] vb = vmix(row(r_p, cx1), row(vint, cx1),
    row(r_n, cx1), vmode, vhalf);
  // Square-law weight from the top four phase bits
  wire [3:0] hf = hacc[15:12];
  wire [7:0] hf2 = {4'h0, hf} * {4'h0, hf};
  wire [4:0] hw = {1'b0, hf2[7:4]};
  wire [PIX_W+4:0] hblend = {5'b00000, va} * (13'(5'd16 - hw))
    + {5'b00000, vb} * {8'h00, hw};
  logic [PIX_W-1:0] hpix;
  always_comb begin
    case (hmode)
      OSC_MODE_NEAREST: hpix = hacc[15] ? vb : va;
      OSC_MODE_FILT_A: hpix = hblend[PIX_W+3:4];
      default: hpix = va;
    endcase
  end

  // Line sequencer
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_IDLE;
      dly_cnt <= 8'h00;
      wx <= 10'h000;
      ocnt <= 11'h000;
      blank_line <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: if (dst_line_start && !field_start) begin
          ocnt <= 11'h000;
          blank_line <= !line_on;
          if (line_on && need_more) begin
            state <= ST_STROBE;
          end else begin
            state <= ST_OUT;
          end
        end
        ST_STROBE: begin
          dly_cnt <= 8'h00;
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          dly_cnt <= dly_cnt + 8'h01;
          if (dly_cnt >= line_request_delay) begin
            wx <= 10'h000;
            state <= ST_FETCH;
          end
        end
        ST_FETCH: if (link.pix_valid) begin
          wx <= wx + 10'h001;
          if (wx + 10'h001 >= src_pix) begin
            state <= (src_got + 10'd1 <= vint + 10'd1
              && src_got + 10'd1 < src_lines) ? ST_STROBE : ST_OUT;
          end
        end
        ST_OUT: begin
          ocnt <= ocnt + 11'h001;
          if (ocnt + 11'h001 >= oend) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (link.pix_valid && link.pix_ready) begin
      lbuf[{src_got[1:0], wx}] <= link.pix_data;
    end
  end

  // Field and line position tracking
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      src_got <= 10'h000;
      dline <= 11'h000;
      vacc <= '0;
      hacc <= '0;
      odd_eff <= 1'b0;
    end else if (field_start) begin
      src_got <= 10'h000;
      dline <= 11'h000;
      odd_eff <= field_odd ^ cfg[0][OSC_SWAP_BIT];
      // Odd field starts one source line down
      vacc <= (progressive_to_interlace_enable && (field_odd ^ cfg[0][OSC_SWAP_BIT]))
        ? osc_pos_t'(26'h0010000) : '0;
    end else begin
      if (state == ST_IDLE && dst_line_start) begin
        dline <= dline + 11'h001;
        hacc <= '0;
      end
      if (state == ST_FETCH && link.pix_valid
          && wx + 10'h001 >= src_pix) begin
        src_got <= src_got + 10'h001;
      end
      if (state == ST_OUT && !blank_line && ocnt >= hoff) begin
        hacc <= hacc + osc_pos_t'(hstep);
      end
      if (state == ST_OUT && !blank_line && ocnt + 11'h001 >= oend) begin
        vacc <= vacc + vstep;
      end
    end
  end

  // Offset margin and blank lines output black
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_pix <= '0;
      out_valid <= 1'b0;
      out_field <= 1'b0;
    end else begin
      out_valid <= state == ST_OUT;
      out_pix <= (state == ST_OUT && !blank_line && ocnt >= hoff)
        ? hpix : '0;
      out_field <= odd_eff;
    end
  end

  assign link.line_start_strobe = state == ST_STROBE;
  assign link.request = state == ST_FETCH;
  assign link.pix_ready = state == ST_FETCH;
  assign busy = state != ST_IDLE;
endmodule

/* tb/osc_props.sv */
// Link checker: watches the interface between scaler and controller.
// Assumes it sits beside osc_link_if, fed its signals by name.
`timescale 1ns/1ps
module osc_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic line_start_strobe,
  input wire logic request,
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire logic [7:0] pix_data,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  logic [7:0] shadow [14];
  logic [7:0] exp_q;
  logic [8:0] gap;
  logic [9:0] acc;
  logic rd_hit;
  logic in_rng;
  logic [3:0] idx;
  assign in_rng = reg_addr >= 8'h90 && reg_addr <= 8'h9d;
  assign idx = 4'(reg_addr - 8'h90);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Own copy of the config, so readback needs no design internals
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < 14; i++) shadow[i] <= 8'h00;
    end else if (reg_wr && in_rng) begin
      shadow[idx] <= (idx == 4'h2 || idx == 4'h5) ?
        {reg_wdata[7:1], 1'b0} : reg_wdata;
    end
  end
  always_ff @(posedge clk_sys) begin
    rd_hit <= !rst && reg_rd && in_rng;
    exp_q <= shadow[idx];
  end
  // Gap saturates so a long idle spell cannot wrap into a false match
  always_ff @(posedge clk_sys) begin
    if (rst || line_start_strobe) begin
      gap <= 9'h000;
    end else if (gap != 9'h1ff) begin
      gap <= gap + 9'h001;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rst || line_start_strobe) begin
      acc <= 10'h000;
    end else if (pix_valid && pix_ready) begin
      acc <= acc + 10'h001;
    end
  end
  a_strobe_single: assert property (
    line_start_strobe |=> !line_start_strobe) else $error("strobe too long");
  a_request_delay: assert property (
    $rose(request) |-> gap == {1'b0, shadow[13]} + 9'h001)
    else $error("request rose at wrong delay");
  a_no_early_request: assert property (
    line_start_strobe |-> !request ##1 !request)
    else $error("request too soon after strobe");
  a_ready_follows: assert property (pix_ready == request)
    else $error("ready differs from request");
  a_request_stands: assert property (request && !pix_valid |=> request)
    else $error("request dropped without a word");
  a_line_words: assert property (
    $fell(request) |-> acc == {shadow[3][5:4], shadow[2]})
    else $error("word count per line wrong");
  a_word_held: assert property (
    pix_valid && !pix_ready |=> pix_valid && $stable(pix_data))
    else $error("stalled word changed");
  a_rdata_quiet: assert property (
    !$past(reg_rd) || $past(reg_addr) >= 8'h9e |-> reg_rdata == 8'h00)
    else $error("read data not zero");
  a_cfg_readback: assert property (rd_hit |-> reg_rdata == exp_q)
    else $error("config readback wrong");
endmodule

/* tb/test_overscan_scan_converter.sv */
// Bench: both ends joined by the link, host driven through its port.
// Assumes one 40 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps
module test_overscan_scan_converter;
  import osc_pkg::*;
  logic clk_sys, rst, dst_line_start, field_start, field_odd, frame_start;
  logic [7:0] reg_addr, reg_wdata, h_rdata, out_pix;
  logic reg_wr, reg_rd, out_valid, out_field, busy;
  int fail_count = 0;
  int num_checks = 0;
  int ov_cnt = 0;
  logic [7:0] seen [64];
  osc_link_if #(.PIX_W(8)) link_i (.clk_sys(clk_sys), .rst(rst));
  osc_scaler_dev #(.PIX_W(8), .MAX_PIX(1024)) u_osc_scaler_dev (
    .clk_sys(clk_sys), .rst(rst), .link(link_i),
    .dst_line_start(dst_line_start), .field_start(field_start),
    .field_odd(field_odd), .out_pix(out_pix), .out_valid(out_valid),
    .out_field(out_field), .busy(busy));
  osc_gfx_ctrl #(.PIX_W(8)) u_osc_gfx_ctrl (
    .clk_sys(clk_sys), .rst(rst), .link(link_i), .frame_start(frame_start),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(h_rdata));
  osc_props chk_i (
    .clk_sys(clk_sys), .rst(rst),
    .line_start_strobe(link_i.line_start_strobe), .request(link_i.request),
    .pix_valid(link_i.pix_valid), .pix_ready(link_i.pix_ready),
    .pix_data(link_i.pix_data), .reg_addr(link_i.reg_addr),
    .reg_wdata(link_i.reg_wdata), .reg_wr(link_i.reg_wr),
    .reg_rd(link_i.reg_rd), .reg_rdata(link_i.reg_rdata));
  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;
  // Slot log only counts up; each test takes its own base
  always @(posedge clk_sys) begin
    if (out_valid === 1'b1) begin
      seen[ov_cnt % 64] = out_pix;
      ov_cnt = ov_cnt + 1;
    end
  end
  task automatic chk(string what, logic [15:0] e, logic [15:0] got);
    num_checks++;
    if (got !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e, string what);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk(what, 16'(e), 16'(h_rdata));
  endtask
  // Rounded step for a shrink from s to d samples
  function automatic logic [15:0] ratio(int s, int d);
    return 16'((s * 65536 + d / 2) / d - 65536);
  endfunction
  // Rows around source line r at column x; the source sends x + line
  function automatic int vcol(int vm, int r, int x);
    int p, c, n;
    p = x + ((r > 0) ? r - 1 : 0);
    c = x + r;
    n = c + 1;
    case (vm)
      2: return (p + 2 * c + n) / 4;
      3: return (p + 6 * c + n) / 8;
      default: return c;
    endcase
  endfunction
  // Pixel of image slot j: step of one, plus ratio when hm is not 0, then mode's pick
  function automatic int exp_pix(int hm, int vm, int vr, int j, int sp,
                                 logic [15:0] hr);
    int pos, x, x1, f, w, a, b;
    pos = j * ((hm == 0) ? 65536 : 65536 + hr);
    x = pos / 65536;
    f = pos % 65536;
    x1 = (x + 1 < sp) ? x + 1 : x;
    a = vcol(vm, vr, x);
    b = vcol(vm, vr, x1);
    w = (f / 4096) * (f / 4096) / 16;
    case (hm)
      1: return (f >= 32768) ? b : a;
      2: return (a * (16 - w) + b * w) / 16;
      default: return a;
    endcase
  endfunction
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #(25 * 80000);
    fail_count++;
    results();
  end
  initial begin
    int k, spix, dpix, line_request_delay, image_horizontal_offset, e, vr, base;
    logic [15:0] hr;
    logic sw;
    {dst_line_start, field_start, field_odd, frame_start} = 4'h0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h00000;
    rst = 1'b1;
    void'($urandom(17));
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    rd(OSC_REG_CTRL, OSC_CTRL_RESET, "ctrl_reset");
    rd(GFX_REG_PIX_LO, 8'h00, "host_pix_reset");
    wr(OSC_REG_TEST_A, 8'h5a);
    rd(OSC_REG_TEST_A, 8'h00, "test_reg");
    rd(8'h50, 8'h00, "unmapped");
    for (int i = 0; i < 4; i++) begin
      spix = 2 * $urandom_range(16, 4);
      dpix = 2 * $urandom_range(spix / 2, 4);
      line_request_delay = $urandom_range(12, 0);
      image_horizontal_offset = $urandom_range(3, 0);
      sw = (i == 3);
      hr = ratio(spix, dpix);
      wr(OSC_REG_CTRL, {2'b00, sw, 2'(i % 3), 2'(i), 1'(i)});
      wr(OSC_REG_SRC_LINES, 8'h08);
      wr(OSC_REG_DST_LINES, 8'h08);
      wr(OSC_REG_SRC_HIGH, 8'h00);
      wr(OSC_REG_DST_HIGH, 8'h00);
      wr(OSC_REG_SRC_PIX, 8'(spix + 1));
      wr(OSC_REG_DST_PIX, 8'(dpix + 1));
      wr(OSC_REG_HRATIO_LO, hr[7:0]);
      wr(OSC_REG_HRATIO_HI, hr[15:8]);
      wr(OSC_REG_VRATIO_LO, 8'h00);
      wr(OSC_REG_VRATIO_HI, 8'h00);
      wr(OSC_REG_IMAGE_VERTICAL_OFFSET, 8'h00);
      wr(OSC_REG_IMAGE_HORIZONTAL_OFFSET, 8'(image_horizontal_offset));
      wr(OSC_REG_LINE_DELAY, 8'(line_request_delay));
      wr(GFX_REG_PIX_LO, 8'(spix + 1));
      wr(GFX_REG_PIX_HI, 8'h00);
      wr(GFX_REG_CTRL, 8'h01);
      rd(OSC_REG_SRC_PIX, 8'(spix), "src_pix");
      rd(OSC_REG_DST_PIX, 8'(dpix), "dst_pix");
      rd(OSC_REG_HRATIO_HI, hr[15:8], "hratio_hi");
      @(posedge clk_sys);
      frame_start <= 1'b1;
      field_start <= 1'b1;
      field_odd <= 1'($urandom);
      @(posedge clk_sys);
      {frame_start, field_start} <= 2'b00;
      @(posedge clk_sys);
      dst_line_start <= 1'b1;
      base = ov_cnt;
      @(posedge clk_sys);
      dst_line_start <= 1'b0;
      #1 k = 1;
      while (link_i.request !== 1'b1 && k < 700) begin
        @(posedge clk_sys);
        #1 k++;
      end
      // Strobe cycle, then the wait state counts nlr + 1 edges
      chk("request_delay", 16'(line_request_delay + 3), 16'(k));
      // A second start while busy must be ignored
      @(posedge clk_sys);
      dst_line_start <= 1'b1;
      @(posedge clk_sys);
      dst_line_start <= 1'b0;
      k = 0;
      while (busy !== 1'b0 && k < 5000) begin
        @(posedge clk_sys);
        #1 k++;
      end
      repeat (3) @(posedge clk_sys);
      #1 chk("out_slots", 16'(image_horizontal_offset * 4 + dpix), 16'(ov_cnt - base));
      vr = (i % 2 == 1) ? int'(field_odd ^ sw) : 0;
      for (int s = 0; s < image_horizontal_offset * 4 + dpix; s++) begin
        e = (s < image_horizontal_offset * 4) ? 0
          : exp_pix(i % 3, i, vr, s - image_horizontal_offset * 4, spix, hr);
        chk("out_pix", 16'(e), {8'h00, seen[(base + s) % 64]});
      end
      chk("out_field", {15'h0000, field_odd ^ sw}, {15'h0000, out_field});
      $display("test %0d done", i);
    end
    results();
  end
endmodule
